// ==== hw/ctrt_pkg.sv ====
// Package of offsets, field layouts, reset values and timing for the card-mode tuning registers
package ctrt_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [5:0] CTRT_ADDR_CARD_SETTINGS = 6'h1C;
  localparam logic [5:0] CTRT_ADDR_RX_TUNE       = 6'h1D;
  localparam logic [7:0] CTRT_RST_CARD_SETTINGS  = 8'h62;
  localparam logic [7:0] CTRT_RST_RX_TUNE        = 8'h00;
  localparam logic [7:0] CTRT_RX_TUNE_WMASK      = 8'h7F;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRT_SENS_LSB     = 5;
  localparam int CTRT_TAU_LSB      = 3;
  localparam int CTRT_HALT_BIT     = 2;
  localparam int CTRT_WAIT_LSB     = 0;
  localparam int CTRT_FAST_BIT     = 6;
  localparam int CTRT_DELAY_BIT    = 5;
  localparam int CTRT_PARDIS_BIT   = 4;
  localparam int CTRT_WIDEBW_BIT   = 3;
  localparam int CTRT_HPMAN_BIT    = 2;
  localparam int CTRT_HPSEL_LSB    = 0;

  // ---------------------------------------------------------------
  // Protocol constants
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRT_REQ_ALLOWED_HALT = 8'h52;
  localparam logic [3:0] CTRT_MIN_RESP_BASE    = 4'h7;
  localparam logic [3:0] CTRT_SRC_SEL_A        = 4'hE;
  localparam logic [3:0] CTRT_SRC_SEL_B        = 4'hF;
  localparam int         CTRT_OUT_DELAY_FC     = 128;
  localparam int         CTRT_FC_PER_CLK       = 1;

  typedef enum logic [1:0] {
    CTRT_RESP_IDLE  = 2'b00,
    CTRT_RESP_COUNT = 2'b01,
    CTRT_RESP_READY = 2'b11
  } ctrt_resp_state_t;
endpackage

// ==== hw/ctrt_delay_line.sv ====
// Fixed-length shift delay for the secure-module signal output
`timescale 1ns/10ps
`default_nettype none
module ctrt_delay_line #(
  parameter int DEPTH = 128
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic enable_in,
  input  wire logic sig_in,
  output logic      sig_out
);
  typedef struct packed {
    logic [DEPTH-1:0] taps;
  } ctrt_dl_state_t;

  ctrt_dl_state_t s_q;
  ctrt_dl_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.taps = {s_q.taps[DEPTH-2:0], sig_in};
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Bypass path keeps standard timing when the delay is off
  assign sig_out = enable_in ? s_q.taps[DEPTH-1] : sig_in;
endmodule
`default_nettype wire

// ==== hw/ctrt_regs.sv ====
// Card/target settings and manual receiver tuning registers with their control logic
//
// Contract
// - Halt flag marks halted card state, host/FSM set
// - While halted accept only request byte 52h
// - Field reset clears the halt flag
// - Minimum response time is 7 plus field bits
// - Early transmit start waits for minimum time
// - Late start sends at once when bit-synchronised
// - Bits 7..5 set pause decoder sensitivity
// - Bits 4..3 set pause decoder time constant
// - Fast filter bit selects fast pause filter
// - Delay bit delays secure signal output
// - Parity disable: no generation, no check
// - Wide bandwidth bit widens recovery PLL
// - Manual select off: corner follows receive mode
// - Corner field picks 106/212/424/848 kHz
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module ctrt_regs #(
  parameter int OUT_DELAY_CYCLES = ctrt_pkg::CTRT_OUT_DELAY_FC / ctrt_pkg::CTRT_FC_PER_CLK
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Register port
  input  wire logic [5:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // Card state machine and field events
  input  wire logic       rf_reset_in,
  input  wire logic       fsm_halt_set_in,
  input  wire logic       card_mode_106_in,
  // Received request check
  input  wire logic       req_valid_in,
  input  wire logic [7:0] req_code_in,
  output logic            req_accept_out,
  // Response timing, one pulse per data bit
  input  wire logic       rx_end_in,
  input  wire logic       bit_tick_in,
  input  wire logic       bit_sync_ok_in,
  input  wire logic       tx_start_in,
  output logic            tx_go_out,
  output logic            tx_pending_out,
  // Receive mode for the automatic corner, and secure output source select
  input  wire logic [1:0] rx_mode_corner_in,
  input  wire logic [3:0] secure_out_source_select_in,
  // Secure signal path
  input  wire logic       secure_signal_raw_in,
  output logic            secure_signal_out,
  // Decoded controls
  output logic      [2:0] pause_decoder_sensitivity_out,
  output logic      [1:0] pause_decoder_time_constant_out,
  output logic            card_halt_flag_out,
  output logic            fast_pause_filter_out,
  output logic            parity_gen_en_out,
  output logic            parity_check_en_out,
  output logic            wide_pll_bandwidth_out,
  output logic      [1:0] highpass_corner_out
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                 card_target_settings;
    logic [7:0]                 receiver_manual_tune;
    logic [7:0]                 rdata;
    logic [3:0]                 bit_cnt;
    logic                       pending;
    logic                       go;
    logic                       accept;
    ctrt_pkg::ctrt_resp_state_t resp;
  } ctrt_state_t;

  ctrt_state_t s_q;
  ctrt_state_t s_d;

  logic [1:0] response_delay_extra_bits;
  logic [3:0] min_resp_bits;
  logic       halt_now;

  assign response_delay_extra_bits = s_q.card_target_settings[ctrt_pkg::CTRT_WAIT_LSB +: 2];
  assign min_resp_bits = ctrt_pkg::CTRT_MIN_RESP_BASE + {2'h0, response_delay_extra_bits};
  assign halt_now      = s_q.card_target_settings[ctrt_pkg::CTRT_HALT_BIT];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    s_d.go     = 1'b0;
    s_d.accept = 1'b0;
    s_d.rdata  = 8'h00;

    // Register writes
    if (reg_wr_in) begin
      if (reg_addr_in == ctrt_pkg::CTRT_ADDR_CARD_SETTINGS) begin
        s_d.card_target_settings = reg_wdata_in;
      end else if (reg_addr_in == ctrt_pkg::CTRT_ADDR_RX_TUNE) begin
        s_d.receiver_manual_tune = reg_wdata_in & ctrt_pkg::CTRT_RX_TUNE_WMASK;
      end
    end

    // Internal set only in 106 kbit card operation
    if (fsm_halt_set_in && card_mode_106_in) begin
      s_d.card_target_settings[ctrt_pkg::CTRT_HALT_BIT] = 1'b1;
    end
    // Field reset overrides every setter: the halted state cannot outlive it
    if (rf_reset_in) begin
      s_d.card_target_settings[ctrt_pkg::CTRT_HALT_BIT] = 1'b0;
    end

    // Register reads, data valid the cycle after
    if (reg_rd_in) begin
      if (reg_addr_in == ctrt_pkg::CTRT_ADDR_CARD_SETTINGS) begin
        s_d.rdata = s_q.card_target_settings;
      end else if (reg_addr_in == ctrt_pkg::CTRT_ADDR_RX_TUNE) begin
        s_d.rdata = s_q.receiver_manual_tune & ctrt_pkg::CTRT_RX_TUNE_WMASK;
      end else begin
        s_d.rdata = 8'h00;
      end
    end

    // Request filtering
    if (req_valid_in) begin
      s_d.accept = !halt_now || (req_code_in == ctrt_pkg::CTRT_REQ_ALLOWED_HALT);
    end

    // Response timing
    if (tx_start_in) begin
      s_d.pending = 1'b1;
    end
    case (s_q.resp)
      ctrt_pkg::CTRT_RESP_IDLE: begin
        if (rx_end_in) begin
          s_d.bit_cnt = 4'h0;
          s_d.resp    = ctrt_pkg::CTRT_RESP_COUNT;
        end
      end
      ctrt_pkg::CTRT_RESP_COUNT: begin
        if (bit_tick_in) begin
          s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          if (s_q.bit_cnt + 4'h1 >= min_resp_bits) begin
            s_d.resp = ctrt_pkg::CTRT_RESP_READY;
          end
        end
      end
      ctrt_pkg::CTRT_RESP_READY: begin
        // Frame leaves as soon as bit sync is valid, without waiting for a bit tick
        if ((s_q.pending || tx_start_in) && bit_sync_ok_in) begin
          s_d.go      = 1'b1;
          s_d.pending = 1'b0;
          s_d.resp    = ctrt_pkg::CTRT_RESP_IDLE;
        end
      end
      default: begin
        s_d.resp = ctrt_pkg::CTRT_RESP_IDLE;
      end
    endcase
    // A new reception restarts the wait
    if (rx_end_in && s_q.resp != ctrt_pkg::CTRT_RESP_IDLE) begin
      s_d.bit_cnt = 4'h0;
      s_d.resp    = ctrt_pkg::CTRT_RESP_COUNT;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_q.card_target_settings <= ctrt_pkg::CTRT_RST_CARD_SETTINGS;
      s_q.receiver_manual_tune <= ctrt_pkg::CTRT_RST_RX_TUNE;
      s_q.rdata                <= 8'h00;
      s_q.bit_cnt              <= 4'h0;
      s_q.pending              <= 1'b0;
      s_q.go                   <= 1'b0;
      s_q.accept               <= 1'b0;
      s_q.resp                 <= ctrt_pkg::CTRT_RESP_READY;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata_out  = s_q.rdata;
  assign req_accept_out = s_q.accept;
  assign tx_go_out      = s_q.go;
  // Held while a started frame waits out the minimum time
  assign tx_pending_out = s_q.pending;

  assign pause_decoder_sensitivity_out   = s_q.card_target_settings[ctrt_pkg::CTRT_SENS_LSB +: 3];
  assign pause_decoder_time_constant_out = s_q.card_target_settings[ctrt_pkg::CTRT_TAU_LSB +: 2];
  assign card_halt_flag_out              = halt_now;
  assign fast_pause_filter_out           = s_q.receiver_manual_tune[ctrt_pkg::CTRT_FAST_BIT];
  assign parity_gen_en_out      = !s_q.receiver_manual_tune[ctrt_pkg::CTRT_PARDIS_BIT];
  assign parity_check_en_out    = !s_q.receiver_manual_tune[ctrt_pkg::CTRT_PARDIS_BIT];
  assign wide_pll_bandwidth_out = s_q.receiver_manual_tune[ctrt_pkg::CTRT_WIDEBW_BIT];
  // Automatic corner tracks receive mode unless manual select is set
  assign highpass_corner_out = s_q.receiver_manual_tune[ctrt_pkg::CTRT_HPMAN_BIT]
                             ? s_q.receiver_manual_tune[ctrt_pkg::CTRT_HPSEL_LSB +: 2]
                             : rx_mode_corner_in;

  // ---------------------------------------------------------------
  // Secure output delay
  // ---------------------------------------------------------------
  // Source select is only observed; misuse is software's concern
  logic unused_src_sel;
  assign unused_src_sel = ^secure_out_source_select_in;

  ctrt_delay_line #(
    .DEPTH (OUT_DELAY_CYCLES)
  ) u_delay (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .enable_in (s_q.receiver_manual_tune[ctrt_pkg::CTRT_DELAY_BIT]),
    .sig_in    (secure_signal_raw_in),
    .sig_out   (secure_signal_out)
  );
endmodule
`default_nettype wire

// ==== verification/ctrt_field_model.sv ====
// Field-side model: reader bit ticks and secure-module signal
`timescale 1ns/10ps
`default_nettype none
module ctrt_field_model (
  input  wire logic clk_in,
  input  wire logic rst_in,
  output logic      bit_tick_out,
  output logic      secure_raw_out
);
  logic [1:0] div_q;
  logic [4:0] lfsr_q;
  // One data bit every 4 clocks; raw signal from a 31-step sequence so no short delay aliases
  always_ff @(posedge clk_in) begin
    div_q          <= rst_in ? 2'h0 : div_q + 2'h1;
    bit_tick_out   <= !rst_in && (div_q == 2'h3);
    lfsr_q         <= rst_in ? 5'h01 : {lfsr_q[3:0], lfsr_q[4] ^ lfsr_q[2]};
    secure_raw_out <= rst_in ? 1'b0 : lfsr_q[4];
  end
endmodule
`default_nettype wire

// ==== verification/ctrt_regs_properties.sv ====
// Port checker of the card-mode tuning registers
`timescale 1ns/10ps
`default_nettype none
module ctrt_regs_checker (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       rf_reset_in,
  input wire logic       req_valid_in,
  input wire logic [7:0] req_code_in,
  input wire logic       req_accept_out,
  input wire logic       rx_end_in,
  input wire logic       bit_tick_in,
  input wire logic       bit_sync_ok_in,
  input wire logic       tx_go_out,
  input wire logic [2:0] pause_decoder_sensitivity_out,
  input wire logic [1:0] pause_decoder_time_constant_out,
  input wire logic       card_halt_flag_out,
  input wire logic       parity_gen_en_out,
  input wire logic       parity_check_en_out
);
  logic [3:0] tick_q;
  logic [1:0] wait_q;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Ticks since reception end; idle after reset counts as long past
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tick_q <= 4'hF;
      wait_q <= 2'h2;
    end else begin
      if (rx_end_in)
        tick_q <= 4'h0;
      else if (bit_tick_in && tick_q != 4'hF)
        tick_q <= tick_q + 4'h1;
      if (reg_wr_in && reg_addr_in == 6'h1C)
        wait_q <= reg_wdata_in[1:0];
    end
  end
  a_rsvd_reads_zero: assert property (reg_rd_in && reg_addr_in == 6'h1D |=> !reg_rdata_out[7])
    else $error("reserved bit read as one");
  a_halt_blocks_req: assert property (req_valid_in && card_halt_flag_out && req_code_in != 8'h52 |=> !req_accept_out)
    else $error("request accepted while halted");
  a_req_accepted: assert property (req_valid_in && (!card_halt_flag_out || req_code_in == 8'h52) |=> req_accept_out)
    else $error("valid request dropped");
  a_field_reset_clear: assert property (rf_reset_in |=> !card_halt_flag_out)
    else $error("halt flag survived field reset");
  a_min_resp_time: assert property (tx_go_out |-> tick_q >= 4'h7 + {2'h0, wait_q})
    else $error("transmit before minimum response time");
  a_go_needs_sync: assert property (tx_go_out |-> $past(bit_sync_ok_in) ##1 !tx_go_out)
    else $error("transmit start without sync or too long");
  a_decoder_fields: assert property (reg_wr_in && reg_addr_in == 6'h1C |=>
    {pause_decoder_sensitivity_out, pause_decoder_time_constant_out} == $past(reg_wdata_in[7:3]))
    else $error("decoder fields not taken from write");
  a_parity_switch: assert property (reg_wr_in && reg_addr_in == 6'h1D |=>
    parity_gen_en_out == !$past(reg_wdata_in[4]) && parity_check_en_out == parity_gen_en_out)
    else $error("parity enables wrong");
  c_tx_go: cover property (tx_go_out);
  c_halted_req: cover property (req_valid_in && card_halt_flag_out);
  c_reset_halt: cover property (rf_reset_in && card_halt_flag_out);
endmodule
bind ctrt_regs ctrt_regs_checker ctrt_regs_checker_i (.*);
`default_nettype wire

// ==== verification/ctrt_regs_tb_top.sv ====
// Self-checking bench of the card-mode tuning registers
`timescale 1ns/10ps
`default_nettype none
module ctrt_regs_tb_top;
  logic       clk_in, rst_in, reg_wr_in, reg_rd_in, rf_reset_in, fsm_halt_set_in, card_mode_106_in;
  logic       req_valid_in, rx_end_in, bit_tick_in, bit_sync_ok_in, tx_start_in, secure_signal_raw_in;
  logic       req_accept_out, tx_go_out, tx_pending_out, secure_signal_out, card_halt_flag_out;
  logic       fast_pause_filter_out, parity_gen_en_out, parity_check_en_out, wide_pll_bandwidth_out;
  logic [1:0] rx_mode_corner_in, pause_decoder_time_constant_out, highpass_corner_out;
  logic [2:0] pause_decoder_sensitivity_out;
  logic [3:0] secure_out_source_select_in;
  logic [5:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, req_code_in, d, q;
  logic [4:0] hist;
  integer     seed = 32'h5968E0E0;
  int         fail_count, compares, n;

  ctrt_regs #(.OUT_DELAY_CYCLES(4)) ctrt_regs_i (.*);
  ctrt_field_model ctrt_field_model_i (.clk_in, .rst_in, .bit_tick_out(bit_tick_in),
                                       .secure_raw_out(secure_signal_raw_in));

  function automatic logic [1:0] corner_exp(input logic [7:0] v, input logic [1:0] m);
    return v[2] ? v[1:0] : m;
  endfunction
  task automatic end_sim;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk("rdata", reg_rdata_out, e);
  endtask
  task automatic req(input logic [7:0] c, input logic e);
    @(posedge clk_in);
    req_code_in <= c;
    req_valid_in <= 1'b1;
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    #1 chk("accept", {7'h0, req_accept_out}, {7'h0, e});
  endtask
  // One-cycle pulse on {field reset, halt set, rx end, tx start}
  task automatic ctl(input logic [3:0] v);
    @(posedge clk_in);
    {rf_reset_in, fsm_halt_set_in, rx_end_in, tx_start_in} <= v;
    @(posedge clk_in);
    {rf_reset_in, fsm_halt_set_in, rx_end_in, tx_start_in} <= 4'h0;
    #1;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    step(5000);
    fail_count++;
    end_sim;
  end
  initial begin
    {reg_wr_in, reg_rd_in, rf_reset_in, fsm_halt_set_in, req_valid_in, rx_end_in, tx_start_in} = 7'h00;
    {reg_addr_in, reg_wdata_in, req_code_in, rx_mode_corner_in} = 24'h000000;
    {card_mode_106_in, bit_sync_ok_in, rst_in} = 3'h7;
    secure_out_source_select_in = 4'hE;
    step(4);
    rst_in <= 1'b0;
    rd(6'h1C, 8'h62);
    rd(6'h1D, 8'h00);
    rd(6'h3F, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 12; i++) begin
      d = (i < 4) ? 8'h04 | 8'(i) : 8'($random(seed));
      rx_mode_corner_in <= 2'($random(seed));
      wr(6'h1D, d);
      chk("corner", {6'h0, highpass_corner_out}, {6'h0, corner_exp(d, rx_mode_corner_in)});
      chk("ctl", {4'h0, fast_pause_filter_out, parity_gen_en_out, parity_check_en_out, wide_pll_bandwidth_out},
          {4'h0, d[6], ~d[4], ~d[4], d[3]});
      rd(6'h1D, d & 8'h7F);
      d = 8'($random(seed)) & 8'hFB;
      wr(6'h1C, d);
      chk("decoder", {3'h0, pause_decoder_sensitivity_out, pause_decoder_time_constant_out}, {3'h0, d[7:3]});
      rd(6'h1C, d);
    end
    $display("test register fields done");
    wr(6'h1C, 8'h64);
    req(8'h26, 1'b0);
    req(8'h52, 1'b1);
    ctl(4'h8);
    chk("halt", {7'h0, card_halt_flag_out}, 8'h00);
    req(8'h26, 1'b1);
    card_mode_106_in <= 1'b0;
    ctl(4'h4);
    chk("halt", {7'h0, card_halt_flag_out}, 8'h00);
    card_mode_106_in <= 1'b1;
    ctl(4'hC);
    chk("halt", {7'h0, card_halt_flag_out}, 8'h00);
    ctl(4'h4);
    rd(6'h1C, 8'h64);
    $display("test halt done");
    for (int w = 0; w < 4; w++) begin
      wr(6'h1C, 8'h60 | 8'(w));
      while (bit_tick_in !== 1'b1)
        step(1);
      ctl(4'h2);
      ctl(4'h1);
      chk("pending", {7'h0, tx_pending_out}, 8'h01);
      n = 0;
      for (int k = 0; k < 60 && tx_go_out !== 1'b1; k++) begin
        n += int'(bit_tick_in === 1'b1);
        step(1);
      end
      chk("ticks", 8'(n), 8'(7 + w));
    end
    // Late start needs a fresh reception whose minimum time has run out
    ctl(4'h2);
    step(48);
    bit_sync_ok_in <= 1'b0;
    ctl(4'h1);
    chk("no sync go", {6'h0, tx_go_out, tx_pending_out}, 8'h01);
    bit_sync_ok_in <= 1'b1;
    step(1);
    chk("sync go", {6'h0, tx_go_out, tx_pending_out}, 8'h02);
    ctl(4'h2);
    step(48);
    ctl(4'h1);
    chk("late go", {6'h0, tx_go_out, tx_pending_out}, 8'h02);
    $display("test response time done");
    wr(6'h1D, 8'h00);
    chk("sec", {7'h0, secure_signal_out}, {7'h0, secure_signal_raw_in});
    wr(6'h1D, 8'h20);
    step(8);
    for (int k = 0; k < 16; k++) begin
      hist = {hist[3:0], secure_signal_raw_in};
      if (k > 4)
        chk("sec", {7'h0, secure_signal_out}, {7'h0, hist[4]});
      step(1);
    end
    wr(6'h1D, 8'h00);
    $display("test secure delay done");
    rst_in <= 1'b1;
    step(2);
    rst_in <= 1'b0;
    rd(6'h1C, 8'h62);
    rd(6'h1D, 8'h00);
    $display("test mid reset done");
    end_sim;
  end
endmodule
`default_nettype wire
